// ---- common/csf_pkg.sv ----
// Purpose: Shared constants and types for the CPU status flag block
// Assumes: 16-bit register words on a plain strobe port
// Notes:   Offsets are word indices on the register port

package csf_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CORE_CTRL = 4'h1;
  localparam logic [3:0] OFS_INT_CTRL1 = 4'h2;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int BIT_CARRY = 0;
  localparam int BIT_ZERO = 1;
  localparam int BIT_OVF = 2;
  localparam int BIT_NEG = 3;
  localparam int BIT_REPEAT = 4;
  localparam int BIT_PRIO_LO = 5;
  localparam int BIT_PRIO_HI = 7;
  localparam int BIT_SAT_COMB = 9;
  localparam int BIT_SAT_B = 10;
  localparam int BIT_SAT_A = 11;

  // Core control and interrupt control fields
  localparam int BIT_PRIO_TOP = 3;
  localparam int BIT_NEST_DIS = 15;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0] RST_PRIO_FIELD = 3'h0;
  localparam logic RST_PRIO_TOP = 1'b0;
  localparam logic RST_NEST_DIS = 1'b0;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [15:0] RST_RDATA = 16'h0000;

  // Field value that masks every user interrupt
  localparam logic [2:0] PRIO_BLOCK_ALL = 3'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    CSF_OP_ADD  = 3'h0,
    CSF_OP_ADDC = 3'h1,
    CSF_OP_SUB  = 3'h2,
    CSF_OP_SUBB = 3'h3,
    CSF_OP_LOGIC = 3'h4
  } csf_op_t;

  typedef struct packed {
    logic valid;
    csf_op_t op;
    logic [15:0] opa;
    logic [15:0] opb;
  } csf_alu_req_t;

  typedef struct packed {
    logic upd_nc;
    logic neg;
    logic ovf;
    logic zero;
    logic carry;
  } csf_flags_t;

  typedef struct packed {
    logic load;
    logic top;
    logic [2:0] field;
  } csf_prio_load_t;

  // Places one value bit in an otherwise zero word
  function automatic logic [15:0] csf_bit(input int pos, input logic val);
    logic [15:0] w;
    w = 16'h0000;
    w[pos] = val;
    return w;
  endfunction

endpackage

// ---- rtl/csf_flag_unit.sv ----
// Purpose: Arithmetic flag evaluation for one ALU operation
// Assumes: Operands are 16-bit two's complement words
// Notes:   Purely combinational; the caller registers the result

`timescale 1ns/1ps

module csf_flag_unit (
  input wire csf_pkg::csf_alu_req_t req, // Operation and operands
  input wire logic carry_in, // Present carry/borrow flag
  input wire logic zero_in, // Present zero flag
  output csf_pkg::csf_flags_t flags // Next flag values
);

  logic [16:0] sum;
  logic [15:0] opb_eff;
  logic cin;
  logic is_sub;
  logic res_zero;

  always_comb
  begin
    is_sub = (req.op == csf_pkg::CSF_OP_SUB) || (req.op == csf_pkg::CSF_OP_SUBB);
    opb_eff = is_sub ? ~req.opb : req.opb;
    unique case (req.op)
      csf_pkg::CSF_OP_ADD: cin = 1'b0;
      csf_pkg::CSF_OP_SUB: cin = 1'b1;
      csf_pkg::CSF_OP_ADDC, csf_pkg::CSF_OP_SUBB: cin = carry_in;
      default: cin = 1'b0;
    endcase
    if (req.op == csf_pkg::CSF_OP_LOGIC)
      sum = {1'b0, req.opa};
    else
      sum = {1'b0, req.opa} + {1'b0, opb_eff} + {16'h0000, cin};
    res_zero = (sum[15:0] == 16'h0000);
    flags.upd_nc = (req.op != csf_pkg::CSF_OP_LOGIC);
    flags.neg = sum[15];
    // Same-signed inputs giving a differently signed result
    flags.ovf = (req.opa[15] == opb_eff[15]) && (sum[15] != req.opa[15]);
    // Carry ops only clear zero so multi-word results test whole
    if ((req.op == csf_pkg::CSF_OP_ADDC) || (req.op == csf_pkg::CSF_OP_SUBB))
      flags.zero = zero_in & res_zero;
    else
      flags.zero = res_zero;
    flags.carry = sum[16];
  end

endmodule

// ---- rtl/csf_prio_unit.sv ----
// Purpose: Forms the four-bit CPU priority and the user interrupt block
// Assumes: Inputs are the caller's next-state values, not registered ones
// Notes:   Combinational; the caller registers the outputs

`timescale 1ns/1ps

module csf_prio_unit (
  input wire logic [2:0] field, // Three-bit priority field
  input wire logic top, // Fourth priority bit
  output logic [3:0] prio, // Full priority level
  output logic user_block // All user interrupts masked
);

  always_comb
  begin
    prio = {top, field};
    // Level 7 or any level 8..15 masks user sources
    user_block = top || (field == csf_pkg::PRIO_BLOCK_ALL);
  end

endmodule

// ---- rtl/csf_status_top.sv ----
// Purpose: CPU status register low byte plus saturation bits and priority
// Assumes: One clock, synchronous reset, reads answer one cycle later
// Notes:   Hardware flag updates take precedence over same-cycle writes

`timescale 1ns/1ps

// How it works
// - Bits 7..5 hold priority 0..7; value 7 masks all user interrupts.
// - Top priority bit joins the field; when set, levels 8..15 mask users.
// - Software writes to the priority field are dropped while nesting disabled.
// - Bit 4 mirrors whether a hardware repeat loop is running.
// - Bit 3 follows the sign of each affecting ALU result.
// - Bit 2 flags signed overflow of the last arithmetic result.
// - Bit 1 set by zero result except on carry ops, cleared by latest non-zero result.
// - Bit 0 is carry out of bit 15, doubling as not-borrow.
// - Status writes set saturation flags directly or clear both via combined bit.
module csf_status_top (
  input wire logic mclk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [3:0] reg_addr, // Register word index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  input wire csf_pkg::csf_alu_req_t alu_req, // Flag-affecting ALU operation
  input wire logic repeat_running, // Hardware repeat loop busy
  input wire csf_pkg::csf_prio_load_t irq_prio, // Priority load from interrupt logic
  input wire logic sat_a_set, // Accumulator A saturated
  input wire logic sat_b_set, // Accumulator B saturated
  output logic [15:0] cpu_status_reg, // Status word
  output logic [3:0] cpu_priority, // Full four-bit priority
  output logic user_irq_blocked // All user interrupts masked
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [2:0] cpu_priority_field_ff;
  logic cpu_priority_top_bit_ff;
  logic nesting_disable_ff;
  logic repeat_active_flag_ff;
  logic neg_flag_ff;
  logic signed_overflow_flag_ff;
  logic zero_flag_ff;
  logic carry_flag_ff;
  logic acc_a_saturation_flag_ff;
  logic acc_b_saturation_flag_ff;
  logic [15:0] rdata_ff;
  logic [15:0] status_ff;
  logic [3:0] prio_ff;
  logic user_block_ff;

  logic [2:0] nxt_priority_field;
  logic nxt_priority_top;
  logic nxt_sat_a;
  logic nxt_sat_b;
  logic [15:0] nxt_status;
  logic [15:0] nxt_rdata;
  logic [3:0] prio_comb;
  logic user_block_comb;
  logic wr_status;
  logic wr_core;
  logic wr_int1;
  csf_pkg::csf_flags_t alu_flags;

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb
  begin
    wr_status = reg_wr && (reg_addr == csf_pkg::OFS_STATUS);
    wr_core = reg_wr && (reg_addr == csf_pkg::OFS_CORE_CTRL);
    wr_int1 = reg_wr && (reg_addr == csf_pkg::OFS_INT_CTRL1);
  end

  // ****************************************************************
  // Sub-units
  // ****************************************************************
  csf_flag_unit u_flag (
    .req(alu_req),
    .carry_in(carry_flag_ff),
    .zero_in(zero_flag_ff),
    .flags(alu_flags)
  );

  csf_prio_unit u_prio (
    .field(nxt_priority_field),
    .top(nxt_priority_top),
    .prio(prio_comb),
    .user_block(user_block_comb)
  );

  // ****************************************************************
  // Priority field and top bit
  // ****************************************************************
  // Interrupt logic load wins over a software write in the same cycle
  always_comb
  begin
    nxt_priority_field = cpu_priority_field_ff;
    nxt_priority_top = cpu_priority_top_bit_ff;
    if (wr_status && !nesting_disable_ff)
    begin
      nxt_priority_field = reg_wdata[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO];
    end
    if (wr_core)
    begin
      nxt_priority_top = reg_wdata[csf_pkg::BIT_PRIO_TOP];
    end
    if (irq_prio.load)
    begin
      nxt_priority_field = irq_prio.field;
      nxt_priority_top = irq_prio.top;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cpu_priority_field_ff <= csf_pkg::RST_PRIO_FIELD;
      cpu_priority_top_bit_ff <= csf_pkg::RST_PRIO_TOP;
    end
    else
    begin
      cpu_priority_field_ff <= nxt_priority_field;
      cpu_priority_top_bit_ff <= nxt_priority_top;
    end
  end

  // ****************************************************************
  // Nesting disable control
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      nesting_disable_ff <= csf_pkg::RST_NEST_DIS;
    end
    else if (wr_int1)
    begin
      nesting_disable_ff <= reg_wdata[csf_pkg::BIT_NEST_DIS];
    end
  end

  // ****************************************************************
  // Repeat loop flag
  // ****************************************************************
  // Read-only to software; tracks the loop controller level
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      repeat_active_flag_ff <= 1'b0;
    end
    else
    begin
      repeat_active_flag_ff <= repeat_running;
    end
  end

  // ****************************************************************
  // Arithmetic flags
  // ****************************************************************
  // ALU result overrides a same-cycle software write of these bits
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      {neg_flag_ff, signed_overflow_flag_ff, zero_flag_ff, carry_flag_ff} <=
        csf_pkg::RST_FLAGS;
    end
    else if (alu_req.valid)
    begin
      neg_flag_ff <= alu_flags.neg;
      zero_flag_ff <= alu_flags.zero;
      if (alu_flags.upd_nc)
      begin
        signed_overflow_flag_ff <= alu_flags.ovf;
        carry_flag_ff <= alu_flags.carry;
      end
    end
    else if (wr_status)
    begin
      neg_flag_ff <= reg_wdata[csf_pkg::BIT_NEG];
      signed_overflow_flag_ff <= reg_wdata[csf_pkg::BIT_OVF];
      zero_flag_ff <= reg_wdata[csf_pkg::BIT_ZERO];
      carry_flag_ff <= reg_wdata[csf_pkg::BIT_CARRY];
    end
  end

  // ****************************************************************
  // Accumulator saturation flags
  // ****************************************************************
  // Hardware set beats any clear; a whole-word write is the safe path
  always_comb
  begin
    nxt_sat_a = acc_a_saturation_flag_ff;
    nxt_sat_b = acc_b_saturation_flag_ff;
    if (wr_status)
    begin
      if (!reg_wdata[csf_pkg::BIT_SAT_COMB])
      begin
        nxt_sat_a = 1'b0;
        nxt_sat_b = 1'b0;
      end
      else
      begin
        nxt_sat_a = reg_wdata[csf_pkg::BIT_SAT_A];
        nxt_sat_b = reg_wdata[csf_pkg::BIT_SAT_B];
      end
    end
    if (sat_a_set)
    begin
      nxt_sat_a = 1'b1;
    end
    if (sat_b_set)
    begin
      nxt_sat_b = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      acc_a_saturation_flag_ff <= 1'b0;
      acc_b_saturation_flag_ff <= 1'b0;
    end
    else
    begin
      acc_a_saturation_flag_ff <= nxt_sat_a;
      acc_b_saturation_flag_ff <= nxt_sat_b;
    end
  end

  // ****************************************************************
  // Status word assembly
  // ****************************************************************
  always_comb
  begin
    nxt_status = csf_pkg::csf_bit(csf_pkg::BIT_CARRY, carry_flag_ff)
      | csf_pkg::csf_bit(csf_pkg::BIT_ZERO, zero_flag_ff)
      | csf_pkg::csf_bit(csf_pkg::BIT_OVF, signed_overflow_flag_ff)
      | csf_pkg::csf_bit(csf_pkg::BIT_NEG, neg_flag_ff)
      | csf_pkg::csf_bit(csf_pkg::BIT_REPEAT, repeat_active_flag_ff)
      | csf_pkg::csf_bit(csf_pkg::BIT_SAT_A, acc_a_saturation_flag_ff)
      | csf_pkg::csf_bit(csf_pkg::BIT_SAT_B, acc_b_saturation_flag_ff)
      | csf_pkg::csf_bit(csf_pkg::BIT_SAT_COMB,
          acc_a_saturation_flag_ff | acc_b_saturation_flag_ff);
    nxt_status[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO] = cpu_priority_field_ff;
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // Status word one cycle behind the flags, priority in step with its field; keeps outputs straight from flops
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      status_ff <= csf_pkg::RST_RDATA;
      prio_ff <= {csf_pkg::RST_PRIO_TOP, csf_pkg::RST_PRIO_FIELD};
      user_block_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      prio_ff <= prio_comb;
      user_block_ff <= user_block_comb;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Unmapped indices and idle cycles return zero
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        csf_pkg::OFS_STATUS: nxt_rdata = nxt_status;
        csf_pkg::OFS_CORE_CTRL:
          nxt_rdata = csf_pkg::csf_bit(csf_pkg::BIT_PRIO_TOP, cpu_priority_top_bit_ff);
        csf_pkg::OFS_INT_CTRL1:
          nxt_rdata = csf_pkg::csf_bit(csf_pkg::BIT_NEST_DIS, nesting_disable_ff);
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rdata_ff <= csf_pkg::RST_RDATA;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb
  begin
    reg_rdata = rdata_ff;
    cpu_status_reg = status_ff;
    cpu_priority = prio_ff;
    user_irq_blocked = user_block_ff;
  end

endmodule

// ---- tb/csf_status_top_asserts.sv ----
// Purpose: Port-level checks of the status flag block
// Assumes: Output word lags stored state by one cycle
// Notes:   Nesting disable is tracked from register writes

`timescale 1ns/1ps

module csf_status_asserts (
  input wire logic mclk, // Clock
  input wire logic reset, // Sync reset
  input wire logic [3:0] reg_addr, // Word index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire csf_pkg::csf_alu_req_t alu_req, // ALU op
  input wire logic repeat_running, // Repeat busy
  input wire csf_pkg::csf_prio_load_t irq_prio, // Priority load
  input wire logic sat_a_set, // Sat A pulse
  input wire logic sat_b_set, // Sat B pulse
  input wire logic [15:0] cpu_status_reg, // Status word
  input wire logic [3:0] cpu_priority, // Full priority
  input wire logic user_irq_blocked // User block
);
  logic nest_ff;
  logic sub;
  logic st_wr;
  logic [16:0] sum;
  logic [3:0] exp_nvzc;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  always_ff @(posedge mclk)
  begin
    if (reset)
      nest_ff <= 1'b0;
    else if (reg_wr && reg_addr == csf_pkg::OFS_INT_CTRL1)
      nest_ff <= reg_wdata[csf_pkg::BIT_NEST_DIS];
  end

  // Reference flags for plain add and subtract only
  always_comb
  begin
    sub = (alu_req.op == csf_pkg::CSF_OP_SUB);
    st_wr = reg_wr && reg_addr == csf_pkg::OFS_STATUS;
    sum = {1'b0, alu_req.opa} + {1'b0, sub ? ~alu_req.opb : alu_req.opb} + {16'h0000, sub};
    exp_nvzc = {sum[15], (alu_req.opa[15] == (sub ^ alu_req.opb[15])) &&
      (sum[15] != alu_req.opa[15]), sum[15:0] == 16'h0000, sum[16]};
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_IRQ_BLOCK: assert property (
    user_irq_blocked == (cpu_priority[3] || cpu_priority[2:0] == csf_pkg::PRIO_BLOCK_ALL))
    else $error("user block wrong");
  // Priority port moves with the field; the status word follows a cycle later
  AST_PRIO_MIRROR: assert property (
    cpu_status_reg[7:5] == $past(cpu_priority[2:0])) else $error("priority mismatch");
  AST_REPEAT: assert property (
    !$past(reset) && !$past(reset, 2) |-> cpu_status_reg[4] == $past(repeat_running, 2))
    else $error("repeat bit wrong");
  AST_ARITH: assert property (
    alu_req.valid && alu_req.op inside {csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB}
    |-> ##2 cpu_status_reg[3:0] == $past(exp_nvzc, 2)) else $error("arith flags wrong");
  AST_LOGIC_KEEP: assert property (
    alu_req.valid && alu_req.op == csf_pkg::CSF_OP_LOGIC |-> ##2
    cpu_status_reg[3] == $past(alu_req.opa[15], 2) && $stable(cpu_status_reg[2]) &&
    $stable(cpu_status_reg[0])) else $error("logic flags wrong");
  AST_NEST_LOCK: assert property (
    st_wr && nest_ff && !irq_prio.load |-> ##2 $stable(cpu_status_reg[7:5]))
    else $error("locked field written");
  AST_PRIO_WRITE: assert property (
    st_wr && !nest_ff && !irq_prio.load |-> ##2 cpu_status_reg[7:5] == $past(reg_wdata[7:5], 2))
    else $error("field write lost");
  AST_TOP_WRITE: assert property (
    reg_wr && reg_addr == csf_pkg::OFS_CORE_CTRL && !irq_prio.load
    |-> ##1 cpu_priority[3] == $past(reg_wdata[3])) else $error("top bit wrong");
  AST_IRQ_LOAD: assert property (
    irq_prio.load |-> ##1 cpu_priority == $past({irq_prio.top, irq_prio.field}))
    else $error("irq load wrong");
  AST_SAT_CLEAR: assert property (
    st_wr && !reg_wdata[9] && !sat_a_set && !sat_b_set |-> ##2 cpu_status_reg[11:9] == 3'h0)
    else $error("sat not cleared");
  AST_SAT_LOAD: assert property (
    st_wr && reg_wdata[9] && !sat_a_set && !sat_b_set
    |-> ##2 cpu_status_reg[11:10] == $past(reg_wdata[11:10], 2)) else $error("sat not loaded");
  // Read data must carry the loop level itself, not only match the status port
  AST_READ: assert property (
    reg_rd && reg_addr == csf_pkg::OFS_STATUS && !$past(reset)
    |=> reg_rdata == cpu_status_reg && reg_rdata[4] == $past(repeat_running, 2))
    else $error("status read wrong");

  cover property (st_wr && nest_ff);
  cover property (alu_req.valid);
  cover property (irq_prio.load);
endmodule

bind csf_status_top csf_status_asserts u_chk (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .alu_req, .repeat_running, .irq_prio, .sat_a_set, .sat_b_set,
  .cpu_status_reg, .cpu_priority, .user_irq_blocked);

// ---- tb/test_csf_status_top.sv ----
// Purpose: Register-level tests of the status flag block
// Assumes: Reads answer in the cycle after the strobe
// Notes:   Expected flags are worked out by hand per operation

`timescale 1ns/1ps

module test_csf_status_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  csf_pkg::csf_alu_req_t alu_req = '0;
  logic repeat_running = 1'b0;
  csf_pkg::csf_prio_load_t irq_prio = '0;
  logic sat_a_set = 1'b0;
  logic sat_b_set = 1'b0;
  logic [15:0] cpu_status_reg;
  logic [3:0] cpu_priority;
  logic user_irq_blocked;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  csf_pkg::csf_op_t ops [9] = '{csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB,
    csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_LOGIC, csf_pkg::CSF_OP_ADDC,
    csf_pkg::CSF_OP_ADDC, csf_pkg::CSF_OP_SUBB};
  logic [15:0] as [9] = '{16'h7fff, 16'hffff, 16'h0005, 16'h0000, 16'h8000, 16'h0000,
    16'hffff, 16'h0001, 16'h0003};
  logic [15:0] bs [9] = '{16'h0001, 16'h0001, 16'h0005, 16'h0001, 16'h0001, 16'h0000,
    16'h0000, 16'h0001, 16'h0003};
  // Order is N, OV, Z, C
  logic [3:0] nvzc [9] = '{4'hc, 4'h3, 4'h3, 4'h8, 4'h5, 4'h7, 4'h3, 4'h0, 4'h8};

  always #5 mclk = ~mclk;

  csf_status_top u_dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .alu_req, .repeat_running, .irq_prio, .sat_a_set, .sat_b_set, .cpu_status_reg,
    .cpu_priority, .user_irq_blocked);

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Saturation pulses ride on the write so a same-cycle race can be staged
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] s);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    {sat_a_set, sat_b_set} <= s;
    @(posedge mclk);
    reg_wr <= 1'b0;
    {sat_a_set, sat_b_set} <= 2'h0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] m,
    input logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(what, e, reg_rdata & m);
  endtask

  task automatic alu(input csf_pkg::csf_op_t op, input logic [15:0] a, input logic [15:0] b);
    @(posedge mclk);
    alu_req <= '{1'b1, op, a, b};
    @(posedge mclk);
    alu_req.valid <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd_chk("status reset", csf_pkg::OFS_STATUS, 16'hffff, 16'h0000);
    rd_chk("core reset", csf_pkg::OFS_CORE_CTRL, 16'hffff, 16'h0000);
    for (int f = 0; f < 8; f++)
    begin
      wr(csf_pkg::OFS_STATUS, {8'h00, 3'(f), 5'h00}, 2'h0);
      rd_chk("field", csf_pkg::OFS_STATUS, 16'h00e0, {8'h00, 3'(f), 5'h00});
      check("block", {15'h0000, f == 7}, {15'h0000, user_irq_blocked});
    end
    wr(csf_pkg::OFS_STATUS, 16'h0060, 2'h0);
    wr(csf_pkg::OFS_CORE_CTRL, 16'h0008, 2'h0);
    rd_chk("top bit", csf_pkg::OFS_CORE_CTRL, 16'h0008, 16'h0008);
    check("priority", 16'h000b, {12'h000, cpu_priority});
    check("top block", 16'h0001, {15'h0000, user_irq_blocked});
    wr(csf_pkg::OFS_CORE_CTRL, 16'h0000, 2'h0);
    wr(csf_pkg::OFS_INT_CTRL1, 16'h8000, 2'h0);
    wr(csf_pkg::OFS_STATUS, 16'h00a0, 2'h0);
    rd_chk("locked", csf_pkg::OFS_STATUS, 16'h00e0, 16'h0060);
    @(posedge mclk);
    irq_prio <= '{1'b1, 1'b0, 3'h6};
    @(posedge mclk);
    irq_prio.load <= 1'b0;
    rd_chk("irq load", csf_pkg::OFS_STATUS, 16'h00e0, 16'h00c0);
    check("irq prio", 16'h0006, {12'h000, cpu_priority});
    wr(csf_pkg::OFS_INT_CTRL1, 16'h0000, 2'h0);
    wr(csf_pkg::OFS_STATUS, 16'h0040, 2'h0);
    rd_chk("unlocked", csf_pkg::OFS_STATUS, 16'h00e0, 16'h0040);
    rd_chk("unmapped", 4'h5, 16'hffff, 16'h0000);
    @(posedge mclk);
    repeat_running <= 1'b1;
    rd_chk("repeat on", csf_pkg::OFS_STATUS, 16'h0010, 16'h0010);
    @(posedge mclk);
    repeat_running <= 1'b0;
    wr(csf_pkg::OFS_STATUS, 16'h0050, 2'h0);
    rd_chk("repeat off", csf_pkg::OFS_STATUS, 16'h00ff, 16'h0040);
    for (int i = 0; i < 9; i++)
    begin
      alu(ops[i], as[i], bs[i]);
      rd_chk("flags", csf_pkg::OFS_STATUS, 16'h000f, {12'h000, nvzc[i]});
    end
    // Whole-word writes only for the saturation flags
    wr(4'hf, 16'hffff, 2'h2);
    rd_chk("sat a", csf_pkg::OFS_STATUS, 16'h0e00, 16'h0a00);
    wr(csf_pkg::OFS_STATUS, 16'h0640, 2'h0);
    rd_chk("sat load", csf_pkg::OFS_STATUS, 16'h0e00, 16'h0600);
    wr(csf_pkg::OFS_STATUS, 16'h0040, 2'h1);
    rd_chk("sat b wins", csf_pkg::OFS_STATUS, 16'h0e00, 16'h0600);
    wr(csf_pkg::OFS_STATUS, 16'h0040, 2'h0);
    rd_chk("sat clear", csf_pkg::OFS_STATUS, 16'h0e00, 16'h0000);
    finish_test();
  end
endmodule
